// [sdf_pkg.sv]
// Shared constants, field positions and carrier types of the synthesizer control word block
package sdf_pkg;
  localparam int WORD_W = 32;

  // Register select codes in the three low control bits
  localparam logic [2:0] SEL_INT   = 3'h0;
  localparam logic [2:0] SEL_LFRAC = 3'h1;
  localparam logic [2:0] SEL_RDIV  = 3'h2;
  localparam logic [2:0] SEL_FUNC  = 3'h3;
  localparam logic [2:0] SEL_TEST  = 3'h4;
  localparam int SEL_LSB = 0;

  // Integer word fields
  localparam int INT_VAL_LSB  = 15;
  localparam int INT_VAL_W    = 12;
  localparam int FRAC_MSB_LSB = 3;
  localparam int FRAC_MSB_W   = 12;
  localparam int MUX_LSB      = 27;
  localparam int MUX_W        = 4;

  // Low fraction word fields
  localparam int LFRAC_LSB = 15;
  localparam int LFRAC_W   = 13;
  localparam int FRAC_W    = 25;

  // Reference divider word fields
  localparam int RD_SLIP_BIT = 28;
  localparam int RD_CP_LSB   = 24;
  localparam int RD_CP_W     = 4;
  localparam int RD_PRE_BIT  = 22;
  localparam int RD_HALF_BIT = 21;
  localparam int RD_DBL_BIT  = 20;
  localparam int RD_CNT_LSB  = 15;
  localparam int RD_CNT_W    = 5;

  // Function word fields
  localparam int FN_SDHOLD_BIT = 14;
  localparam int FN_PREC_BIT   = 7;
  localparam int FN_POL_BIT    = 6;
  localparam int FN_PD_BIT     = 5;
  localparam int FN_TRI_BIT    = 4;
  localparam int FN_CRST_BIT   = 3;

  // Reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Lock detect timing: window is a longest time, so it rounds down
  localparam int CORE_PERIOD_PS = 5000;
  localparam int LOCK_WIN_NS    = 15;
  localparam int LOCK_WIN_CYC   = (LOCK_WIN_NS * 1000) / CORE_PERIOD_PS;
  localparam logic [5:0] LOCK_CNT_LO = 6'h18;
  localparam logic [5:0] LOCK_CNT_HI = 6'h28;

  // Double-buffered reference path settings
  typedef struct packed {
    logic                rdiv_half;
    logic                doubler;
    logic [RD_CNT_W-1:0] rcount;
  } sdf_ref_cfg_type;

  // Function word settings
  typedef struct packed {
    logic sd_hold;
    logic lock_prec;
    logic polarity;
    logic pd;
    logic tristate;
    logic cnt_rst;
  } sdf_func_type;
endpackage

// [sdf_serial_rx.sv]
// Serial input shift register, clocked by the host's serial clock
`timescale 1ns/1ps
module sdf_serial_rx #(
  parameter int WORD_W = 32
) (
  input  wire logic              serial_clk,
  input  wire logic              rst_n,
  input  wire logic              serial_data,
  output logic [WORD_W-1:0]      shift_word
);
  // Most significant bit enters first, control bits arrive last
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_word <= '0;
    end else begin
      shift_word <= {shift_word[WORD_W-2:0], serial_data}; // see [RULE25] see [RULE27]
    end
  end
endmodule

// [sdf_ref_path.sv]
// Reference path: edge select, 5-bit divider and divide-by-two stage
`timescale 1ns/1ps
module sdf_ref_path
  import sdf_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             reference_input,
  input  wire sdf_pkg::sdf_ref_cfg_type cfg,
  input  wire logic             hold,
  output logic                  detector_tick
);
  logic                ref_s1;
  logic                ref_s2;
  logic                ref_s3;
  logic [RD_CNT_W-1:0] div_cnt;
  logic                half_phase;

  // Pin synchroniser; the third stage only serves edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
    end else begin
      ref_s1 <= reference_input;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
    end
  end

  // Falling edge always counts, rising edge only with the doubler on
  wire                fall_edge   = ref_s3 & ~ref_s2;
  wire                rise_edge   = ~ref_s3 & ref_s2;
  wire                active_edge = fall_edge | (cfg.doubler & rise_edge); // see [RULE10] see [RULE11]
  // Count 0 wraps to 31 as terminal, giving divide by 32
  wire [RD_CNT_W-1:0] term_cnt    = cfg.rcount - 5'h01; // see [RULE13]
  wire                div_done    = (div_cnt == term_cnt);
  wire                r_tick      = active_edge & div_done & ~hold;

  // Divider is held at its load state while held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (hold) begin
      div_cnt <= '0; // see [RULE19]
    end else if (active_edge) begin
      div_cnt <= div_done ? '0 : div_cnt + 5'h01; // see [RULE13]
    end
  end

  // Toggle stage passes every second divider output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_phase <= 1'b0;
    end else if (hold) begin
      half_phase <= 1'b0;
    end else if (r_tick && cfg.rdiv_half) begin
      half_phase <= ~half_phase; // see [RULE9]
    end
  end

  assign detector_tick = r_tick & (~cfg.rdiv_half | half_phase); // see [RULE9]
endmodule

// [sdf_function_regs.sv]
// Control word registers of the fractional-N synthesizer with serial load and reference path
`timescale 1ns/1ps
// How it works
// [RULE1] Control bits 001, 010, 011, 100 pick low fraction, divider, function, test.
// [RULE2] Fraction is 12 integer-word bits on top of 13 low fraction bits.
// [RULE3] Host writes zero in reserved bits; test word bits 31..3 are zero.
// [RULE4] Slip reduction enable bit turns on the slip reduction output.
// [RULE5] Host uses slip reduction only with 50% duty and minimum pump current.
// [RULE6] Host uses slip reduction only with positive detector polarity.
// [RULE7] Pump current code comes from divider word bits 27..24.
// [RULE8] Host picks 8/9 above 3 GHz; integer at least 23 or 75.
// [RULE9] Halver bit inserts a toggle divide-by-two before the detector.
// [RULE10] Doubler bit doubles the reference before the divider.
// [RULE11] Doubler off: falling edge only; on: both edges are active.
// [RULE12] Host keeps doubler off above 30 MHz reference.
// [RULE13] Five-bit reference divider gives ratios 1 to 32.
// [RULE14] Hold bit zero resets the modulator on every integer word write.
// [RULE15] Lock after 24 or 40 consecutive detector cycles within 15 ns.
// [RULE16] Polarity bit sets detector polarity; host sets it from VCO slope.
// [RULE17] Power-down bit one powers down, zero restores operation.
// [RULE18] Power-down keeps every register value.
// [RULE19] Power-down loads counters, tristates pump, clears lock; serial load continues.
// [RULE20] Tristate bit holds the charge pump in three-state.
// [RULE21] Counter reset bit holds the RF counters in reset.
// [RULE22] Host programs test, function, divider, low fraction, then integer word.
// [RULE23] Host keeps detector frequency at or below 32 MHz.
// [RULE24] Low fraction and divider settings apply only after an integer word write; slip enable and prescaler bits apply at once.
// [RULE25] Bits shift on rising serial clock; latch strobe high transfers the word.
// [RULE26] Control bits 000 select the integer word.
// [RULE27] Words arrive MSB first so control bits are the last clocked.
// [RULE28] Detector rate is ref times (1+D) over count times (1+T).
module sdf_function_regs
  import sdf_pkg::*;
#(
  parameter int REF_FREQ_KHZ = 10000
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  serial_clk,
  input  wire logic                  serial_data,
  input  wire logic                  latch_strobe,
  input  wire logic                  reference_input,
  input  wire logic                  phase_error_pulse,
  output logic [INT_VAL_W-1:0]       int_value,
  output logic [FRAC_W-1:0]          frac_value,
  output logic [MUX_W-1:0]           mux_select,
  output logic [RD_CP_W-1:0]         pump_current,
  output logic                       slip_enable,
  output logic                       prescaler_select,
  output logic                       pd_polarity,
  output logic                       power_down,
  output logic                       pump_three_state,
  output logic                       rf_counter_reset,
  output logic                       sd_modulator_reset,
  output logic                       lock_detect,
  output logic                       phase_detector_tick,
  output logic [31:0]                phase_detector_khz
);
  import sdf_pkg::*;

  logic [WORD_W-1:0]     shift_word;
  logic                  strobe_s1;
  logic                  strobe_s2;
  logic                  strobe_s3;
  logic [FRAC_MSB_W-1:0] frac_msb;
  logic [LFRAC_W-1:0]    lfrac_pend;
  logic [LFRAC_W-1:0]    lfrac_act;
  sdf_ref_cfg_type       ref_pend;
  sdf_ref_cfg_type       ref_act;
  logic [RD_CP_W-1:0]    cp_pend;
  sdf_func_type          func;
  logic [WORD_W-1:0]     test_word;
  logic                  err_s1;
  logic                  err_s2;
  logic [2:0]            err_run;
  logic                  bad_seen;
  logic [5:0]            lock_cnt;

  // Link-side shift register on the serial clock
  sdf_serial_rx #(.WORD_W(WORD_W)) u_rx (
    .serial_clk  (serial_clk),
    .rst_n       (rst_n),
    .serial_data (serial_data),
    .shift_word  (shift_word)
  );

  // Strobe crossing; the shifted word is quiet while the strobe is high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
    end else begin
      strobe_s1 <= latch_strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
    end
  end

  // Word decode on the rising strobe
  wire       load_pulse = strobe_s2 & ~strobe_s3; // see [RULE25]
  wire [2:0] sel        = shift_word[SEL_LSB +: 3];
  wire       wr_int     = load_pulse & (sel == SEL_INT); // see [RULE26]
  wire       wr_lfrac   = load_pulse & (sel == SEL_LFRAC); // see [RULE1]
  wire       wr_rdiv    = load_pulse & (sel == SEL_RDIV); // see [RULE1]
  wire       wr_func    = load_pulse & (sel == SEL_FUNC); // see [RULE1]
  wire       wr_test    = load_pulse & (sel == SEL_TEST); // see [RULE1]
  wire [RD_CNT_W-1:0] w_rcount = shift_word[RD_CNT_LSB +: RD_CNT_W];

  // Integer word fields apply at once and release the double buffer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_value  <= '0;
      frac_msb   <= '0;
      mux_select <= '0;
      lfrac_act  <= '0;
      ref_act    <= '0;
      pump_current <= '0;
    end else if (wr_int) begin
      int_value  <= shift_word[INT_VAL_LSB +: INT_VAL_W];
      frac_msb   <= shift_word[FRAC_MSB_LSB +: FRAC_MSB_W];
      mux_select <= shift_word[MUX_LSB +: MUX_W];
      lfrac_act  <= lfrac_pend; // see [RULE24]
      ref_act    <= ref_pend; // see [RULE24]
      pump_current <= cp_pend; // see [RULE24] see [RULE7]
    end
  end

  // Pending halves of the double-buffered settings
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfrac_pend <= '0;
      ref_pend   <= '0;
      cp_pend    <= '0;
    end else begin
      if (wr_lfrac) begin
        lfrac_pend <= shift_word[LFRAC_LSB +: LFRAC_W];
      end
      if (wr_rdiv) begin
        ref_pend <= '{rdiv_half: shift_word[RD_HALF_BIT],
                      doubler:   shift_word[RD_DBL_BIT],
                      rcount:    w_rcount};
        cp_pend  <= shift_word[RD_CP_LSB +: RD_CP_W]; // see [RULE7]
      end
    end
  end

  // Single-buffered divider word bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slip_enable      <= 1'b0;
      prescaler_select <= 1'b0;
    end else if (wr_rdiv) begin
      slip_enable      <= shift_word[RD_SLIP_BIT]; // see [RULE4]
      prescaler_select <= shift_word[RD_PRE_BIT];
    end
  end

  // Function and test words; nothing here is cleared by power-down
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      func      <= '0;
      test_word <= WORD_RST;
    end else begin
      if (wr_func) begin
        func <= '{sd_hold:   shift_word[FN_SDHOLD_BIT],
                  lock_prec: shift_word[FN_PREC_BIT],
                  polarity: shift_word[FN_POL_BIT],
                  pd:       shift_word[FN_PD_BIT],
                  tristate: shift_word[FN_TRI_BIT],
                  cnt_rst:  shift_word[FN_CRST_BIT]}; // see [RULE18]
      end
      if (wr_test) begin
        test_word <= shift_word; // see [RULE3]
      end
    end
  end

  // Modulator reset pulse follows each integer write unless held off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_modulator_reset <= 1'b0;
    end else begin
      sd_modulator_reset <= wr_int & ~func.sd_hold; // see [RULE14]
    end
  end

  // Fraction join, and status levels derived from the function word
  assign frac_value       = {frac_msb, lfrac_act}; // see [RULE2]
  assign power_down       = func.pd; // see [RULE17]
  assign pd_polarity      = func.polarity; // see [RULE16]
  assign pump_three_state = func.tristate | func.pd; // see [RULE20] see [RULE19]
  assign rf_counter_reset = func.cnt_rst | func.pd; // see [RULE21] see [RULE19]

  sdf_ref_path u_ref (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .reference_input (reference_input),
    .cfg             (ref_act),
    .hold            (func.pd),
    .detector_tick   (phase_detector_tick)
  );

  // Detector rate estimate; the divide costs area but saves software a lookup
  wire [5:0]  r_ratio = (ref_act.rcount == 5'h00) ? 6'h20 : {1'b0, ref_act.rcount};
  wire [6:0]  denom   = ref_act.rdiv_half ? {r_ratio, 1'b0} : {1'b0, r_ratio};
  wire [31:0] numer   = 32'(REF_FREQ_KHZ) << ref_act.doubler;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_detector_khz <= 32'h0000_0000;
    end else begin
      phase_detector_khz <= numer / {25'h000_0000, denom}; // see [RULE28]
    end
  end

  // Phase error pulse synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_s1 <= 1'b0;
      err_s2 <= 1'b0;
    end else begin
      err_s1 <= phase_error_pulse;
      err_s2 <= err_s1;
    end
  end

  // An error pulse longer than the window spoils the current cycle
  wire       bad_now  = err_s2 & (err_run >= 3'(LOCK_WIN_CYC)); // see [RULE15]
  wire [5:0] lock_thr = func.lock_prec ? LOCK_CNT_HI : LOCK_CNT_LO;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_run <= '0;
    end else if (!err_s2) begin
      err_run <= '0;
    end else if (err_run != 3'h7) begin
      err_run <= err_run + 3'h1;
    end
  end

  // Set wins over the clear at the detector tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_seen <= 1'b0;
    end else if (bad_now) begin
      bad_seen <= 1'b1;
    end else if (phase_detector_tick || func.pd) begin
      bad_seen <= 1'b0;
    end
  end

  // Consecutive good detector cycles; power-down resets the detector
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt <= '0;
    end else if (func.pd) begin
      lock_cnt <= '0; // see [RULE19]
    end else if (phase_detector_tick) begin
      if (bad_seen || bad_now) begin
        lock_cnt <= '0; // see [RULE15]
      end else if (lock_cnt < LOCK_CNT_HI) begin
        lock_cnt <= lock_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_detect <= 1'b0;
    end else begin
      lock_detect <= ~func.pd & (lock_cnt >= lock_thr); // see [RULE15]
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_lfrac_decode: assert property (wr_lfrac |=> lfrac_pend == $past(shift_word[27:15])) // see [RULE1]
    else $error("low fraction word not captured");
  a_dbb_wait: assert property (!wr_int |=> $stable(frac_value) && $stable(pump_current)) // see [RULE24]
    else $error("buffered setting changed without integer write");
  a_frac_join: assert property (wr_int |=> frac_value[12:0] == $past(lfrac_pend)) // see [RULE2]
    else $error("fraction low bits not taken from pending value");
  a_sd_reset: assert property (sd_modulator_reset == $past(wr_int && !func.sd_hold)) // see [RULE14]
    else $error("modulator reset pulse wrong");
  a_lock_count: assert property ($rose(lock_detect) |-> $past(lock_cnt) >= $past(lock_thr)) // see [RULE15]
    else $error("lock asserted before enough cycles");
  a_pd_unlock: assert property (power_down |=> !lock_detect) // see [RULE19]
    else $error("lock detect not cleared in power-down");
  a_pd_pump: assert property (power_down && !wr_func |=> pump_three_state && rf_counter_reset) // see [RULE19]
    else $error("pump or counters active in power-down");
  a_pd_retain: assert property (power_down && !load_pulse |=> $stable(int_value) && $stable(ref_pend)) // see [RULE18]
    else $error("register changed in power-down");
  a_slip_direct: assert property (wr_rdiv |=> slip_enable == $past(shift_word[28])) // see [RULE4]
    else $error("slip enable not applied");
  a_cnt_reset: assert property (wr_func && shift_word[3] |=> rf_counter_reset [*2]) // see [RULE21]
    else $error("counter reset not held");
  a_pd_no_tick: assert property (power_down |-> !phase_detector_tick) // see [RULE19]
    else $error("detector tick during power-down");
  a_test_capture: assert property (wr_test |=> test_word == $past(shift_word)) // see [RULE1]
    else $error("test word not captured");

  c_int_write: cover property (wr_lfrac ##[1:200] wr_int);
  c_lock: cover property ($rose(lock_detect));
  c_power_down: cover property ($rose(power_down) ##[1:300] $fell(power_down));
  c_halver_tick: cover property (phase_detector_tick && ref_act.rdiv_half);
endmodule

// [sdf_host_model.sv]
// Host controller model driving the three-wire serial write link
`timescale 1ns/1ps
module sdf_host_model (
  input  wire logic core_clk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      latch_strobe
);
  // Link idles with its clock still and the strobe low
  initial begin
    serial_clk   = 1'b0;
    serial_data  = 1'b0;
    latch_strobe = 1'b0;
  end

  // Shift one word MSB first; the 15 ns link clock runs only inside the frame
  task automatic write_word(input logic [31:0] w);
    // Off-grid start keeps the link clock out of step with the core clock
    #1.3;
    for (int i = 31; i >= 0; i--) begin
      serial_data = w[i];
      #7.5 serial_clk = 1'b1;
      #7.5 serial_clk = 1'b0;
    end
    // Released line shows the inverse so a stale bit cannot pass for data
    serial_data = ~serial_data;
    @(posedge core_clk);
    latch_strobe <= 1'b1;
    repeat (4) @(posedge core_clk);
    latch_strobe <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the synthesizer control word block
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  import sdf_pkg::*;
  localparam int REF_KHZ = 10000;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 reference_input = 1'b0;
  logic                 phase_error_pulse = 1'b0;
  wire                  serial_clk;
  wire                  serial_data;
  wire                  latch_strobe;
  logic [INT_VAL_W-1:0] int_value;
  logic [FRAC_W-1:0]    frac_value;
  logic [MUX_W-1:0]     mux_select;
  logic [RD_CP_W-1:0]   pump_current;
  logic                 slip_enable, prescaler_select, pd_polarity, power_down;
  logic                 pump_three_state, rf_counter_reset, sd_modulator_reset;
  logic                 lock_detect, phase_detector_tick;
  logic [31:0]          phase_detector_khz;
  int                   fail_count = 0;
  int                   total_checks = 0;
  int                   sd_pulses = 0;
  int                   ticks = 0;
  logic [31:0]          seed = 32'h33aa_b6e7;
  logic                 hold = 1'b0;
  logic [11:0]          cur_int = 12'h000;
  logic [24:0]          cur_frac = 25'h000_0000;
  logic [3:0]           cur_cp = 4'h0;
  logic [31:0]          cur_freq = REF_KHZ / 32;

  always #2.5 core_clk = ~core_clk;

  sdf_function_regs #(.REF_FREQ_KHZ(REF_KHZ)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk), .serial_data(serial_data),
    .latch_strobe(latch_strobe), .reference_input(reference_input),
    .phase_error_pulse(phase_error_pulse), .int_value(int_value), .frac_value(frac_value),
    .mux_select(mux_select), .pump_current(pump_current), .slip_enable(slip_enable),
    .prescaler_select(prescaler_select), .pd_polarity(pd_polarity), .power_down(power_down),
    .pump_three_state(pump_three_state), .rf_counter_reset(rf_counter_reset),
    .sd_modulator_reset(sd_modulator_reset), .lock_detect(lock_detect),
    .phase_detector_tick(phase_detector_tick), .phase_detector_khz(phase_detector_khz));

  sdf_host_model host (
    .core_clk(core_clk), .serial_clk(serial_clk), .serial_data(serial_data),
    .latch_strobe(latch_strobe));

  // Count one-cycle pulses of the modulator reset and detector tick
  always @(posedge core_clk) begin
    if (sd_modulator_reset === 1'b1) sd_pulses++;
    if (phase_detector_tick === 1'b1) ticks++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected detector rate; a count of zero divides by 32
  function automatic logic [31:0] exp_freq(logic half, logic dbl, logic [4:0] cnt);
    int r;
    r = (cnt == 5'h00) ? 32 : int'(cnt);
    return REF_KHZ * (1 + dbl) / (r * (1 + half));
  endfunction

  // Word builders keep every reserved bit at zero
  function automatic logic [31:0] fn_w(logic h, logic lp, logic pol, logic pd, logic ts,
                                       logic cr);
    logic [31:0] w;
    w = {29'h0, SEL_FUNC};
    w[FN_SDHOLD_BIT] = h;
    w[FN_PREC_BIT] = lp;
    w[FN_POL_BIT] = pol;
    w[FN_PD_BIT] = pd;
    w[FN_TRI_BIT] = ts;
    w[FN_CRST_BIT] = cr;
    return w;
  endfunction

  function automatic logic [31:0] rd_w(logic slip, logic [3:0] cp, logic pre, logic half,
                                       logic dbl, logic [4:0] cnt);
    logic [31:0] w;
    w = {29'h0, SEL_RDIV};
    w[RD_SLIP_BIT] = slip;
    w[RD_CP_LSB+:RD_CP_W] = cp;
    w[RD_PRE_BIT] = pre;
    w[RD_HALF_BIT] = half;
    w[RD_DBL_BIT] = dbl;
    w[RD_CNT_LSB+:RD_CNT_W] = cnt;
    return w;
  endfunction

  task automatic final_report();
    $display("checks=%0d failures=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Function word write and its immediate level outputs
  task automatic set_fn(input logic h, lock_detect_precision_sel, pol, pd, ts, cr);
    hold = h;
    host.write_word(fn_w(h, lock_detect_precision_sel, pol, pd, ts, cr));
    `CHK(pd_polarity, pol)
    `CHK(power_down, pd)
    `CHK(pump_three_state, ts | pd)
    `CHK(rf_counter_reset, cr | pd)
    if (pd) `CHK(lock_detect, 1'b0)
    `CHK(int_value, cur_int)
  endtask

  // Divider, low fraction, then integer word; buffered fields wait for the integer write
  task automatic prog(input logic slip, input logic [3:0] cp, input logic pre, half, dbl,
                      input logic [4:0] cnt);
    logic [31:0] r;
    logic [31:0] m;
    int          sd0;
    r = rnd();
    m = rnd();
    host.write_word(rd_w(slip, cp, pre, half, dbl, cnt));
    `CHK(slip_enable, slip)
    `CHK(prescaler_select, pre)
    `CHK(pump_current, cur_cp)
    `CHK(phase_detector_khz, cur_freq)
    host.write_word({4'h0, r[12:0], 12'h000, SEL_LFRAC});
    `CHK(frac_value, cur_frac)
    cur_int = 12'd75 + {1'b0, m[14:4]};
    cur_frac = {m[26:15], r[12:0]};
    cur_cp = cp;
    cur_freq = exp_freq(half, dbl, cnt);
    sd0 = sd_pulses;
    host.write_word({1'b0, m[3:0], cur_int, m[26:15], SEL_INT});
    `CHK(int_value, cur_int)
    `CHK(frac_value, cur_frac)
    `CHK(mux_select, m[3:0])
    `CHK(pump_current, cur_cp)
    `CHK(phase_detector_khz, cur_freq)
    `CHK(sd_pulses - sd0, hold ? 0 : 1)
  endtask

  // Toggle the reference pin every four core cycles, then let ticks settle
  task automatic ref_edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      reference_input <= ~reference_input;
    end
    repeat (8) @(posedge core_clk);
  endtask

  // Divider from load state; power-down pulse puts divider and halver at load
  task automatic tick_run(input logic half, dbl, input logic [4:0] cnt);
    int t0;
    int ex;
    prog(1'b0, 4'(rnd()), 1'b0, half, dbl, cnt);
    set_fn(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    set_fn(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    t0 = ticks;
    ref_edges(48);
    ex = (dbl ? 48 : 24) / ((cnt == 5'h00 ? 32 : int'(cnt)) * (1 + half));
    `CHK(ticks - t0 >= ex - 1 && ticks - t0 <= ex, 1'b1)
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    int          n;
    repeat (5) @(posedge core_clk);
    `CHK(phase_detector_khz, 32'h0000_0000)
    `CHK(power_down, 1'b0)
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(phase_detector_khz, cur_freq)
    host.write_word({29'h0, SEL_TEST});
    `CHK(int_value, cur_int)
    set_fn(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    prog(1'b1, 4'h0, 1'b0, 1'b1, 1'b0, 5'h05);
    // Polarity goes random once slip reduction has been switched off again
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      set_fn(r[0], r[1], r[16] | (k == 0), 1'b0, r[2], r[3]);
      prog(1'b0, r[7:4], r[8], r[9], r[10], r[15:11]);
    end
    // Unused select codes must leave every output alone
    for (int c = 5; c < 8; c++) begin
      r = rnd();
      host.write_word({r[31:3], 3'(c)});
      `CHK(int_value, cur_int)
      `CHK(pump_current, cur_cp)
      `CHK(power_down, 1'b0)
    end
    // Words still load and latch while powered down
    set_fn(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    prog(1'b0, 4'h9, 1'b1, 1'b0, 1'b1, 5'h1f);
    set_fn(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    tick_run(1'b0, 1'b0, 5'h03);
    tick_run(1'b0, 1'b1, 5'h03);
    tick_run(1'b1, 1'b1, 5'h02);
    tick_run(1'b1, 1'b0, 5'h01);
    tick_run(1'b0, 1'b0, 5'h01);
    // Lock needs an unbroken run of good cycles; a bad one restarts the run
    for (int prec = 0; prec < 2; prec++) begin
      n = prec ? 40 : 24;
      set_fn(1'b1, 1'(prec), 1'b1, 1'b1, 1'b0, 1'b0);
      set_fn(1'b1, 1'(prec), 1'b1, 1'b0, 1'b0, 1'b0);
      ref_edges(20);
      phase_error_pulse <= 1'b1;
      repeat (6) @(posedge core_clk);
      phase_error_pulse <= 1'b0;
      ref_edges(2 * (n - 2));
      `CHK(lock_detect, 1'b0)
      ref_edges(8);
      `CHK(lock_detect, 1'b1)
    end
    final_report();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
endmodule
